// File: logic/codec_port_pkg.sv
package codec_port_pkg;

    // Register map on the APB bus (byte addresses)
    localparam logic [31:0] STATUS_ADDR = 32'h8000_2018;
    localparam logic [31:0] CONTROL_ADDR = 32'h8000_2040;

    // Status register field positions
    localparam int ATS_BIT = 0;
    localparam int ARS_BIT = 1;
    localparam int TTS_BIT = 2;
    localparam int TRS_BIT = 3;
    localparam int ERR_LO_BIT = 4;
    localparam int NOT_FULL_EMPTY_LO_BIT = 8;
    localparam int WRITE_DONE_BIT = 12;
    localparam int READ_DONE_BIT = 13;
    localparam int AUDIO_ENA_BIT = 14;
    localparam int TEL_ENA_BIT = 15;
    localparam int STATUS_USED_W = 16;

    // Control register field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MASK_LO_BIT = 1;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // FIFO service thresholds, in entries
    localparam int FIFO_LEVEL_W = 4;
    localparam logic [FIFO_LEVEL_W-1:0] TX_SERVICE_MAX = 4'h4;
    localparam logic [FIFO_LEVEL_W-1:0] RX_SERVICE_MIN = 4'h6;

    // Codec register addresses and enable bits inside control register B
    localparam int CODEC_ADDR_W = 4;
    localparam logic [CODEC_ADDR_W-1:0] TEL_CTRL_B_REG = 4'h6;
    localparam logic [CODEC_ADDR_W-1:0] AUDIO_CTRL_B_REG = 4'h8;
    localparam int CODEC_IN_ENA_BIT = 14;
    localparam int CODEC_OUT_ENA_BIT = 15;

    // Path index inside two-element vectors
    localparam int AUDIO = 0;
    localparam int TELECOM = 1;

    typedef struct packed {
        logic [FIFO_LEVEL_W-1:0] tel_rx;
        logic [FIFO_LEVEL_W-1:0] tel_tx;
        logic [FIFO_LEVEL_W-1:0] audio_rx;
        logic [FIFO_LEVEL_W-1:0] audio_tx;
    } fifo_levels_t;

    typedef struct packed {
        logic valid;
        logic [CODEC_ADDR_W-1:0] addr;
        logic [15:0] data;
    } codec_write_t;

    typedef struct packed {
        logic port_enable;
        logic [3:0] irq_mask;
        logic [3:0] error;
        logic write_done;
        logic read_done;
        logic audio_ena;
        logic tel_ena;
        logic audio_pend_valid;
        logic audio_pend_value;
        logic tel_pend_valid;
        logic tel_pend_value;
        logic [1:0] tx_repeat;
        logic [31:0] prdata;
    } state_t;

endpackage

// File: logic/codec_port_status_register.sv
// Behaviour
// - Telecom enabled sets after register 6 write with bit 14/15, latch, next frame sync.
// - Same sequence with bits 14 and 15 both zero clears telecom enabled.
// - Telecom enabled flag never contributes to the interrupt request.
// - Software writes to read-only status bits have no effect.
// - Bits 31 to 16 ignore writes and read as zero.
// - Audio tx service high when enabled and four or fewer entries; maskable request.
// - Audio rx service high when enabled and six or more entries; maskable request.
// - Telecom tx service high when enabled and four or fewer entries; maskable request.
// - Telecom rx service high when enabled and six or more entries; maskable request.
// - Audio tx fetch from empty FIFO sets underrun bit 4 and requests interrupt.
// - Audio rx write into full FIFO sets overrun bit 5 and requests interrupt.
// - Telecom tx fetch from empty FIFO sets underrun bit 6 and requests interrupt.
// - Telecom rx write into full FIFO sets overrun bit 7 and requests interrupt.
// - Bit 8 reads one while audio tx FIFO has a free entry.
// - Bit 9 reads one while audio rx FIFO holds a valid entry.
// - Bit 10 reads one while telecom tx FIFO has a free entry.
// - Bit 11 reads one while telecom rx FIFO holds a valid entry.
// - Bit 12 sets once a codec register write has completed; else stays zero.
// - Bit 13 sets once a codec read value is back in the data register.
// - Bit 14 follows bits 14/15 of the codec audio control register B.
// - Bit 15 follows bits 14/15 of the codec telecom control register B.
// - Any access to the codec data register clears bits 12 and 13.
// - During tx underrun, repeat last sample until new data reaches the FIFO bottom.
// - On rx overrun discard each new sample and re-set overrun until space exists.
module codec_port_status_register #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire codec_port_pkg::fifo_levels_t i_fifo_levels,
    input wire logic [1:0] i_tx_fetch,
    input wire logic [1:0] i_rx_push,
    input wire codec_port_pkg::codec_write_t i_codec_latch,
    input wire logic i_frame_sync,
    input wire logic i_codec_write_done,
    input wire logic i_codec_read_done,
    input wire logic i_data_reg_access,
    output logic o_port_enable,
    output logic o_service_request,
    output logic [1:0] o_tx_repeat,
    output logic [1:0] o_rx_discard
);

    localparam logic [codec_port_pkg::FIFO_LEVEL_W-1:0] FULL_LEVEL =
        codec_port_pkg::FIFO_LEVEL_W'(FIFO_DEPTH);
    localparam logic [codec_port_pkg::FIFO_LEVEL_W-1:0] EMPTY_LEVEL = '0;

    codec_port_pkg::state_t state;
    codec_port_pkg::state_t next_state;

    logic [3:0] service;
    logic [3:0] not_full_empty;
    logic [3:0] error_set;
    logic [3:0] error_clear;
    logic [1:0] tx_empty;
    logic [1:0] rx_full;
    logic [15:0] status_word;
    logic [31:0] control_word;
    logic setup_phase;
    logic access_phase;
    logic hit_status;
    logic hit_control;
    logic status_write;
    logic control_write;
    logic tel_enable_bits;
    logic audio_enable_bits;

    // Service flags are levels, forced low while the port is disabled
    always_comb
    begin
        service[codec_port_pkg::ATS_BIT] = state.port_enable &&
            (i_fifo_levels.audio_tx <= codec_port_pkg::TX_SERVICE_MAX);
        service[codec_port_pkg::ARS_BIT] = state.port_enable &&
            (i_fifo_levels.audio_rx >= codec_port_pkg::RX_SERVICE_MIN);
        service[codec_port_pkg::TTS_BIT] = state.port_enable &&
            (i_fifo_levels.tel_tx <= codec_port_pkg::TX_SERVICE_MAX);
        service[codec_port_pkg::TRS_BIT] = state.port_enable &&
            (i_fifo_levels.tel_rx >= codec_port_pkg::RX_SERVICE_MIN);
    end

    // Derived straight from the levels, so they cannot be written
    always_comb
    begin
        not_full_empty[0] = i_fifo_levels.audio_tx != FULL_LEVEL;
        not_full_empty[1] = i_fifo_levels.audio_rx != EMPTY_LEVEL;
        not_full_empty[2] = i_fifo_levels.tel_tx != FULL_LEVEL;
        not_full_empty[3] = i_fifo_levels.tel_rx != EMPTY_LEVEL;
    end

    always_comb
    begin
        tx_empty[codec_port_pkg::AUDIO] = i_fifo_levels.audio_tx == EMPTY_LEVEL;
        tx_empty[codec_port_pkg::TELECOM] = i_fifo_levels.tel_tx == EMPTY_LEVEL;
        rx_full[codec_port_pkg::AUDIO] = i_fifo_levels.audio_rx == FULL_LEVEL;
        rx_full[codec_port_pkg::TELECOM] = i_fifo_levels.tel_rx == FULL_LEVEL;
    end

    // Error bit order: audio tx, audio rx, telecom tx, telecom rx
    always_comb
    begin
        error_set[0] = i_tx_fetch[codec_port_pkg::AUDIO] && tx_empty[codec_port_pkg::AUDIO];
        error_set[1] = i_rx_push[codec_port_pkg::AUDIO] && rx_full[codec_port_pkg::AUDIO];
        error_set[2] = i_tx_fetch[codec_port_pkg::TELECOM] && tx_empty[codec_port_pkg::TELECOM];
        error_set[3] = i_rx_push[codec_port_pkg::TELECOM] && rx_full[codec_port_pkg::TELECOM];
    end

    // Samples arriving at a full FIFO are dropped by the datapath
    assign o_rx_discard = i_rx_push & rx_full;

    assign tel_enable_bits = i_codec_latch.data[codec_port_pkg::CODEC_IN_ENA_BIT] ||
        i_codec_latch.data[codec_port_pkg::CODEC_OUT_ENA_BIT];
    assign audio_enable_bits = tel_enable_bits;

    always_comb
    begin
        status_word = '0;
        status_word[codec_port_pkg::TRS_BIT:codec_port_pkg::ATS_BIT] = service;
        status_word[codec_port_pkg::ERR_LO_BIT +: 4] = state.error;
        status_word[codec_port_pkg::NOT_FULL_EMPTY_LO_BIT +: 4] = not_full_empty;
        status_word[codec_port_pkg::WRITE_DONE_BIT] = state.write_done;
        status_word[codec_port_pkg::READ_DONE_BIT] = state.read_done;
        status_word[codec_port_pkg::AUDIO_ENA_BIT] = state.audio_ena;
        status_word[codec_port_pkg::TEL_ENA_BIT] = state.tel_ena;
    end

    always_comb
    begin
        control_word = '0;
        control_word[codec_port_pkg::CTRL_ENABLE_BIT] = state.port_enable;
        control_word[codec_port_pkg::CTRL_MASK_LO_BIT +: 4] = state.irq_mask;
    end

    assign setup_phase = i_psel && !i_penable;
    assign access_phase = i_psel && i_penable;
    assign hit_status = i_paddr == codec_port_pkg::STATUS_ADDR;
    assign hit_control = i_paddr == codec_port_pkg::CONTROL_ADDR;
    assign status_write = access_phase && i_pwrite && hit_status;
    assign control_write = access_phase && i_pwrite && hit_control;

    // Only the error bits respond to a status write; all else is read-only
    assign error_clear = status_write ? i_pwdata[codec_port_pkg::ERR_LO_BIT +: 4] : 4'h0;

    always_comb
    begin
        next_state = state;

        if (control_write)
        begin
            next_state.port_enable = i_pwdata[codec_port_pkg::CTRL_ENABLE_BIT];
            next_state.irq_mask = i_pwdata[codec_port_pkg::CTRL_MASK_LO_BIT +: 4];
        end

        // A new event in the clearing cycle keeps the bit set
        next_state.error = (state.error & ~error_clear) | error_set;

        next_state.write_done = (state.write_done && !i_data_reg_access) || i_codec_write_done;
        next_state.read_done = (state.read_done && !i_data_reg_access) || i_codec_read_done;

        // The value latched in the codec only shows after the next frame sync
        if (i_frame_sync && state.tel_pend_valid)
        begin
            next_state.tel_ena = state.tel_pend_value;
            next_state.tel_pend_valid = 1'b0;
        end
        if (i_frame_sync && state.audio_pend_valid)
        begin
            next_state.audio_ena = state.audio_pend_value;
            next_state.audio_pend_valid = 1'b0;
        end
        // Latch comes after sync so a latch in the sync cycle waits for the next frame
        if (i_codec_latch.valid && i_codec_latch.addr == codec_port_pkg::TEL_CTRL_B_REG)
        begin
            next_state.tel_pend_valid = 1'b1;
            next_state.tel_pend_value = tel_enable_bits;
        end
        if (i_codec_latch.valid && i_codec_latch.addr == codec_port_pkg::AUDIO_CTRL_B_REG)
        begin
            next_state.audio_pend_valid = 1'b1;
            next_state.audio_pend_value = audio_enable_bits;
        end

        // Repeat the last sample until fresh data sits at the FIFO bottom
        for (int i = 0; i < 2; i++)
        begin
            if (i_tx_fetch[i] && tx_empty[i])
            begin
                next_state.tx_repeat[i] = 1'b1;
            end
            else if (!tx_empty[i])
            begin
                next_state.tx_repeat[i] = 1'b0;
            end
        end

        // Read data is captured in the setup cycle so it comes from a flop
        if (setup_phase && !i_pwrite)
        begin
            if (hit_status)
            begin
                next_state.prdata = {16'h0000, status_word};
            end
            else if (hit_control)
            begin
                next_state.prdata = control_word;
            end
            else
            begin
                next_state.prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            state.port_enable <= 1'b0;
            state.irq_mask <= codec_port_pkg::MASK_RESET;
            state.error <= 4'h0;
            state.write_done <= 1'b0;
            state.read_done <= 1'b0;
            state.audio_ena <= 1'b0;
            state.tel_ena <= 1'b0;
            state.audio_pend_valid <= 1'b0;
            state.audio_pend_value <= 1'b0;
            state.tel_pend_valid <= 1'b0;
            state.tel_pend_value <= 1'b0;
            state.tx_repeat <= 2'h0;
            state.prdata <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Zero wait states; unmapped addresses answer with an error
    assign o_pready = 1'b1;
    assign o_pslverr = access_phase && !hit_status && !hit_control;
    assign o_prdata = state.prdata;
    assign o_port_enable = state.port_enable;
    assign o_tx_repeat = state.tx_repeat;

    // Enabled flags stay out of the request on purpose
    assign o_service_request = |(service & state.irq_mask) || |state.error;

endmodule

// File: test/codec_port_status_register_asserts.sv
module codec_port_status_register_asserts #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire codec_port_pkg::fifo_levels_t i_fifo_levels,
    input wire logic [1:0] i_tx_fetch,
    input wire logic [1:0] i_rx_push,
    input wire codec_port_pkg::codec_write_t i_codec_latch,
    input wire logic i_frame_sync,
    input wire logic i_codec_write_done,
    input wire logic i_codec_read_done,
    input wire logic i_data_reg_access,
    input wire logic o_port_enable,
    input wire logic o_service_request,
    input wire logic [1:0] o_tx_repeat,
    input wire logic [1:0] o_rx_discard
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);
    logic rd;
    logic [1:0] tx_empty;
    logic [1:0] rx_full;
    assign rd = i_psel && i_penable && !i_pwrite && i_paddr == codec_port_pkg::STATUS_ADDR;
    assign tx_empty = {i_fifo_levels.tel_tx == 4'h0, i_fifo_levels.audio_tx == 4'h0};
    assign rx_full = {i_fifo_levels.tel_rx == FIFO_DEPTH, i_fifo_levels.audio_rx == FIFO_DEPTH};
    // Read data is captured in the setup cycle, so levels are taken one cycle back
    sequence s_rd;
        i_psel && !i_penable && !i_pwrite && i_paddr == codec_port_pkg::STATUS_ADDR ##1 rd;
    endsequence
    sequence s_tel(logic on);
        i_codec_latch.valid && i_codec_latch.addr == codec_port_pkg::TEL_CTRL_B_REG
            && (|i_codec_latch.data[15:14]) == on ##1 i_frame_sync;
    endsequence
    logic err_event;
    assign err_event = |(i_tx_fetch & tx_empty | i_rx_push & rx_full);
    a_rsvd_zero: assert property (rd |-> o_prdata[31:16] == 16'h0)
        else $error("reserved status bits not zero");
    a_level_flags: assert property (rd |-> o_prdata[11:8] ==
        {$past(i_fifo_levels.tel_rx) != 0, $past(i_fifo_levels.tel_tx) != FIFO_DEPTH,
        $past(i_fifo_levels.audio_rx) != 0, $past(i_fifo_levels.audio_tx) != FIFO_DEPTH})
        else $error("not-full or not-empty flag wrong");
    a_tx_service: assert property (rd |-> o_prdata[2] == ($past(o_port_enable)
        && $past(i_fifo_levels.tel_tx) <= codec_port_pkg::TX_SERVICE_MAX) && o_prdata[0] == ($past(o_port_enable)
        && $past(i_fifo_levels.audio_tx) <= codec_port_pkg::TX_SERVICE_MAX)) else $error("tx service flag wrong");
    a_rx_service: assert property (rd |-> o_prdata[3] == ($past(o_port_enable)
        && $past(i_fifo_levels.tel_rx) >= codec_port_pkg::RX_SERVICE_MIN) && o_prdata[1] == ($past(o_port_enable)
        && $past(i_fifo_levels.audio_rx) >= codec_port_pkg::RX_SERVICE_MIN)) else $error("rx service flag wrong");
    a_rx_discard: assert property (o_rx_discard == (i_rx_push & rx_full))
        else $error("discard does not match push into full fifo");
    a_err_request: assert property (err_event |=> o_service_request)
        else $error("fifo error gave no request");
    a_tel_on: assert property (s_tel(1'b1) ##1 s_rd |-> o_prdata[15])
        else $error("telecom enabled flag not set");
    a_tel_off: assert property (s_tel(1'b0) ##1 s_rd |-> !o_prdata[15])
        else $error("telecom enabled flag not cleared");
    a_write_done: assert property (i_codec_write_done ##1 s_rd |-> o_prdata[12])
        else $error("write completed flag not set");
    a_done_clear: assert property (i_data_reg_access && !i_codec_write_done && !i_codec_read_done
        ##1 !i_codec_write_done && !i_codec_read_done ##1 s_rd |-> o_prdata[13:12] == 2'b00)
        else $error("completion flags not cleared");
endmodule

// File: test/codec_partner.sv
module codec_partner (
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic [3:0] i_reg,
    input wire logic [15:0] i_value,
    output codec_port_pkg::codec_write_t o_latch = '0,
    output logic o_sync = 1'b0,
    output logic o_write_done = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Outside a latch pulse the fields toggle so stale values are never trusted
    always @(posedge i_mclk)
    begin
        o_latch <= i_go ? {1'b1, i_reg, i_value} : {1'b0, ~o_latch.addr, ~o_latch.data};
        o_sync <= o_latch.valid;
        o_write_done <= o_latch.valid;
    end
endmodule

// File: test/codec_port_status_register_tb_top.sv
module codec_port_status_register_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [15:0] lv;
        logic [7:0] ctrl;
        logic [15:0] stat;
        logic srq;
    } row_t;
    localparam row_t ROWS [8] = '{'{16'h0000, 8'h1F, 16'h0505, 1'b1}, '{16'h6565, 8'h1F, 16'h0F0A, 1'b1},
        '{16'h5454, 8'h01, 16'h0F05, 1'b0}, '{16'h8888, 8'h1F, 16'h0A0A, 1'b1}, '{16'h6060, 8'h1E, 16'h0F00, 1'b0},
        '{16'h6565, 8'h03, 16'h0F0A, 1'b0}, '{16'h0060, 8'h05, 16'h0707, 1'b1}, '{16'h0055, 8'h09, 16'h0704, 1'b1}};
    localparam logic [31:0] STAT = codec_port_pkg::STATUS_ADDR;
    localparam logic [31:0] CTRL = codec_port_pkg::CONTROL_ADDR;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [31:0] i_paddr = 32'h0;
    logic [31:0] i_pwdata = 32'h0;
    codec_port_pkg::fifo_levels_t i_fifo_levels = '0;
    logic [1:0] i_tx_fetch = 2'h0;
    logic [1:0] i_rx_push = 2'h0;
    logic i_codec_read_done = 1'b0;
    logic i_data_reg_access = 1'b0;
    logic go = 1'b0;
    logic [3:0] creg = 4'h0;
    logic [15:0] cval = 16'h0;
    codec_port_pkg::codec_write_t i_codec_latch;
    logic i_frame_sync, i_codec_write_done, o_pready, o_pslverr, o_port_enable, o_service_request, slv;
    logic [31:0] o_prdata, rd;
    logic [1:0] o_tx_repeat, o_rx_discard;
    int errors = 0;
    int total_checks = 0;
    initial forever #50 i_mclk = ~i_mclk;
    codec_port_status_register #(.FIFO_DEPTH(8)) DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_fifo_levels(i_fifo_levels), .i_tx_fetch(i_tx_fetch),
        .i_rx_push(i_rx_push), .i_codec_latch(i_codec_latch), .i_frame_sync(i_frame_sync),
        .i_codec_write_done(i_codec_write_done), .i_codec_read_done(i_codec_read_done),
        .i_data_reg_access(i_data_reg_access), .o_port_enable(o_port_enable), .o_service_request(o_service_request),
        .o_tx_repeat(o_tx_repeat), .o_rx_discard(o_rx_discard));
    codec_partner partner (.i_mclk(i_mclk), .i_go(go), .i_reg(creg), .i_value(cval), .o_latch(i_codec_latch),
        .o_sync(i_frame_sync), .o_write_done(i_codec_write_done));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= addr;
        i_pwdata <= data;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do
            @(posedge i_mclk);
        while (o_pready !== 1'b1);
        rd = o_prdata;
        slv = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic st(input string what, input logic [15:0] exp);
        apb(1'b0, STAT, 32'h0);
        check(what, rd, {16'h0, exp});
    endtask
    // Latch lands one edge later and frame sync one after that
    task automatic codec(input logic [3:0] r, input logic [15:0] v);
        @(posedge i_mclk);
        go <= 1'b1;
        creg <= r;
        cval <= v;
        @(posedge i_mclk);
        go <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic finish_test();
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (2000) @(posedge i_mclk);
        errors++;
        finish_test();
    end
    initial
    begin
        repeat (12) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        st("reset status", 16'h0500);
        apb(1'b1, STAT, 32'hF0);
        foreach (ROWS[i])
        begin
            i_fifo_levels <= ROWS[i].lv;
            apb(1'b1, CTRL, {24'h0, ROWS[i].ctrl});
            st("status row", ROWS[i].stat);
            check("flags row", rd[11:8], ROWS[i].stat[11:8]);
            @(negedge i_mclk);
            check("request row", o_service_request, ROWS[i].srq);
            check("enable row", o_port_enable, ROWS[i].ctrl[0]);
            // Back onto the rising edge so the next row's levels are driven there
            @(posedge i_mclk);
        end
        i_fifo_levels <= '0;
        apb(1'b1, CTRL, 32'h1);
        apb(1'b1, STAT, 32'hFFFF_FF0F);
        st("read-only bits", 16'h0505);
        apb(1'b0, 32'h8000_2000, 32'h0);
        check("unmapped", {rd[30:0], slv}, 32'h1);
        // Both tx FIFOs empty and both rx FIFOs full, so every error path fires
        i_fifo_levels <= 16'h8080;
        @(posedge i_mclk);
        i_tx_fetch <= 2'h3;
        i_rx_push <= 2'h3;
        @(negedge i_mclk);
        check("discard", o_rx_discard, 2'h3);
        @(posedge i_mclk);
        i_tx_fetch <= 2'h0;
        i_rx_push <= 2'h0;
        @(negedge i_mclk);
        check("repeat", o_tx_repeat, 2'h3);
        check("error request", o_service_request, 1'b1);
        check("ready", o_pready, 1'b1);
        st("errors", 16'h0FFF);
        apb(1'b1, STAT, 32'h50);
        st("clear two", 16'h0FAF);
        apb(1'b1, STAT, 32'hA0);
        st("clear rest", 16'h0F0F);
        i_fifo_levels <= '0;
        codec(4'h6, 16'h4000);
        st("telecom on", 16'h9505);
        @(negedge i_mclk);
        check("no request", o_service_request, 1'b0);
        codec(4'h8, 16'h8000);
        st("audio on", 16'hD505);
        @(posedge i_mclk);
        i_codec_read_done <= 1'b1;
        @(posedge i_mclk);
        i_codec_read_done <= 1'b0;
        st("read done", 16'hF505);
        @(posedge i_mclk);
        i_data_reg_access <= 1'b1;
        @(posedge i_mclk);
        i_data_reg_access <= 1'b0;
        st("data access", 16'hC505);
        codec(4'h6, 16'h0000);
        st("telecom off", 16'h5505);
        @(posedge i_mclk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(negedge i_mclk);
        check("repeat reset", o_tx_repeat, 2'h0);
        st("second reset", 16'h0500);
        finish_test();
    end
endmodule
bind codec_port_status_register codec_port_status_register_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_fifo_levels(i_fifo_levels), .i_tx_fetch(i_tx_fetch), .i_rx_push(i_rx_push), .i_codec_latch(i_codec_latch),
    .i_frame_sync(i_frame_sync), .i_codec_write_done(i_codec_write_done), .i_codec_read_done(i_codec_read_done),
    .i_data_reg_access(i_data_reg_access), .o_port_enable(o_port_enable), .o_service_request(o_service_request),
    .o_tx_repeat(o_tx_repeat), .o_rx_discard(o_rx_discard));
